//--- rtl/rtoc_core.sv
`default_nettype none
// clock control block: timer, alarm, oscillator control, axi4-lite slave
module rtoc_core
   import rtoc_pkg::*;
#(
   parameter int TIMER_WIDTH = 32
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic osc_amplitude_ok,
   output logic gain_control_enable,
   output logic oscillator_mode_select,
   output logic bias_double_enable,
   output logic low_freq_osc_select,
   output logic crystal_osc_enable,
   output logic alarm_active,
   output logic irq
);
   typedef struct packed {
      logic aw_held;
      logic [3:0] aw_idx;
      logic w_held;
      logic [31:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic run;
      logic aen;
      logic alarm_flag;
      logic auto_reset;
      logic set_busy;
      logic cap_busy;
      logic [1:0] xfer_cnt;
      logic [31:0] capture;
      logic [31:0] alarm;
      logic [4:0] osc;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic irq;
      logic crystal_en;
   } rtoc_core_t;
   rtoc_core_t st, next_st;

   logic [TIMER_WIDTH-1:0] timer_count;
   logic timer_match;
   logic timer_load;
   logic amp_ok;
   logic do_write;
   logic do_read;
   logic [3:0] ar_idx;
   logic [7:0] osc_read;
   logic [7:0] ctl_read;
   logic [31:0] rd_word;
   logic rd_err;
   logic wr_err;

   rtoc_sync #(
      .WIDTH(1)
   ) u_amp_sync (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .async_in(osc_amplitude_ok),
      .sync_out(amp_ok)
   );

   rtoc_timer #(
      .WIDTH(TIMER_WIDTH)
   ) u_timer (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .run(st.run),
      .load(timer_load),
      .load_value(st.capture),
      .alarm_value(st.alarm),
      .count(timer_count),
      .match(timer_match)
   );

   // the load fires in the last busy cycle, then the strobe drops
   assign timer_load = st.set_busy &&
                       (st.xfer_cnt == RTOC_XFER_CYCLES);

   // register views; low oscillator bits read zero
   always_comb begin
      osc_read = 8'h00;
      osc_read[RTOC_OSC_AGC] = st.osc[4];
      osc_read[RTOC_OSC_MODE] = st.osc[3];
      osc_read[RTOC_OSC_BIAS] = st.osc[2];
      osc_read[RTOC_OSC_VLD] = amp_ok;
      osc_read[RTOC_OSC_LFO] = st.osc[0];
      ctl_read = 8'h00;
      ctl_read[RTOC_CTL_RUN] = st.run;
      ctl_read[RTOC_CTL_AEN] = st.aen;
      ctl_read[RTOC_CTL_ALARM_FLAG_AUTORESET] = st.alarm_flag;
      ctl_read[RTOC_CTL_SET] = st.set_busy;
      ctl_read[RTOC_CTL_CAP] = st.cap_busy;
   end

   assign ar_idx = s_axi_araddr[5:2];
   assign do_read = s_axi_arvalid && !st.rvalid;
   assign do_write = st.aw_held && st.w_held && !st.bvalid;
   assign wr_err = (st.aw_idx > RTOC_IDX_IRQ_MASK) ||
                   (st.aw_idx == 4'h6) || (st.aw_idx == 4'h7) ||
                   (st.aw_idx == RTOC_IDX_IRQ_STATUS);

   // read mux; capture and alarm bytes one per word
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_err = 1'b0;
      if (ar_idx <= RTOC_IDX_CAPTURE3) begin
         rd_word[7:0] = st.capture[8*ar_idx[1:0] +: 8];
      end else if (ar_idx >= RTOC_IDX_ALARM0 &&
                   ar_idx <= RTOC_IDX_ALARM3) begin
         rd_word[7:0] = st.alarm[8*ar_idx[1:0] +: 8];
      end else if (ar_idx == RTOC_IDX_CONTROL) begin
         rd_word[7:0] = ctl_read;
      end else if (ar_idx == RTOC_IDX_OSC_CTRL) begin
         rd_word[7:0] = osc_read;
      end else if (ar_idx == RTOC_IDX_IRQ_STATUS) begin
         rd_word[2:0] = st.irq_status;
      end else if (ar_idx == RTOC_IDX_IRQ_MASK) begin
         rd_word[2:0] = st.irq_mask;
      end else if (ar_idx == RTOC_IDX_TIMER_NOW) begin
         rd_word = timer_count;
      end else begin
         rd_err = 1'b1;
      end
   end

   // single next-state process for bus, control and events
   always_comb begin
      logic [2:0] events;
      events = 3'b000;
      next_st = st;
      if (clk_en) begin
         // write channels are taken independently
         if (s_axi_awvalid && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx = s_axi_awaddr[5:2];
         end
         if (s_axi_wvalid && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_lane0 = s_axi_wstrb[0];
         end
         if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
         end
         if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
         end

         // strobe sequencing; capture copies timer when it completes
         if (st.set_busy || st.cap_busy) begin
            if (st.xfer_cnt == RTOC_XFER_CYCLES) begin
               next_st.xfer_cnt = 2'h0;
               if (st.set_busy) begin
                  next_st.set_busy = 1'b0;
                  events[RTOC_IRQ_SET_DONE] = 1'b1;
               end else begin
                  next_st.capture = timer_count;
                  next_st.cap_busy = 1'b0;
                  events[RTOC_IRQ_CAP_DONE] = 1'b1;
               end
            end else begin
               next_st.xfer_cnt = st.xfer_cnt + 2'h1;
            end
         end

         // alarm match; auto reset clears the flag a cycle after the event
         if (st.aen && timer_match && !st.alarm_flag) begin
            next_st.alarm_flag = 1'b1;
            events[RTOC_IRQ_ALARM] = 1'b1;
         end

         if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_err ? RTOC_RESP_SLVERR : RTOC_RESP_OKAY;
            if (!wr_err && st.w_lane0) begin
               if (st.aw_idx <= RTOC_IDX_CAPTURE3) begin
                  next_st.capture[8*st.aw_idx[1:0] +: 8] = st.w_data[7:0];
               end else if (st.aw_idx >= RTOC_IDX_ALARM0 &&
                            st.aw_idx <= RTOC_IDX_ALARM3) begin
                  next_st.alarm[8*st.aw_idx[1:0] +: 8] = st.w_data[7:0];
               end else if (st.aw_idx == RTOC_IDX_CONTROL) begin
                  next_st.run = st.w_data[RTOC_CTL_RUN];
                  next_st.aen = st.w_data[RTOC_CTL_AEN];
                  next_st.auto_reset = st.w_data[RTOC_CTL_ALARM_FLAG_AUTORESET];
                  // disable clears the flag even over a same-cycle match
                  if (!st.w_data[RTOC_CTL_AEN]) begin
                     next_st.alarm_flag = 1'b0;
                  end
                  // one transfer at a time; set wins over capture
                  if (!st.set_busy && !st.cap_busy) begin
                     if (st.w_data[RTOC_CTL_SET]) begin
                        next_st.set_busy = 1'b1;
                        next_st.xfer_cnt = 2'h0;
                     end else if (st.w_data[RTOC_CTL_CAP]) begin
                        next_st.cap_busy = 1'b1;
                        next_st.xfer_cnt = 2'h0;
                     end
                  end
               end else if (st.aw_idx == RTOC_IDX_OSC_CTRL) begin
                  next_st.osc[4] = st.w_data[RTOC_OSC_AGC];
                  next_st.osc[3] = st.w_data[RTOC_OSC_MODE];
                  next_st.osc[2] = st.w_data[RTOC_OSC_BIAS];
                  next_st.osc[0] = st.w_data[RTOC_OSC_LFO];
               end else if (st.aw_idx == RTOC_IDX_IRQ_MASK) begin
                  next_st.irq_mask = st.w_data[2:0];
               end
            end
         end

         // auto reset drops the flag a cycle after the event is seen
         if (st.auto_reset && st.alarm_flag && !events[RTOC_IRQ_ALARM]) begin
            next_st.alarm_flag = 1'b0;
         end

         if (do_read) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word;
            next_st.rresp = rd_err ? RTOC_RESP_SLVERR : RTOC_RESP_OKAY;
            if (ar_idx == RTOC_IDX_IRQ_STATUS) begin
               next_st.irq_status = 3'b000;
            end
         end
         // new events win over the read clear
         next_st.irq_status = next_st.irq_status | events;
         next_st.irq = |(next_st.irq_status & next_st.irq_mask);
         // lfo overrides the mode bit
         next_st.crystal_en = next_st.osc[3] && !next_st.osc[0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = clk_en && !st.aw_held;
   assign s_axi_wready = clk_en && !st.w_held;
   assign s_axi_arready = clk_en && !st.rvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign gain_control_enable = st.osc[4];
   assign oscillator_mode_select = st.osc[3];
   assign bias_double_enable = st.osc[2];
   assign low_freq_osc_select = st.osc[0];
   assign crystal_osc_enable = st.crystal_en;
   assign alarm_active = st.alarm_flag;
   assign irq = st.irq;
endmodule
`default_nettype wire

//--- rtl/rtoc_pkg.sv
`default_nettype none
package rtoc_pkg;
   // indices of the internal register space; byte address is index times 4
   localparam logic [3:0] RTOC_IDX_CAPTURE0 = 4'h0;
   localparam logic [3:0] RTOC_IDX_CAPTURE3 = 4'h3;
   localparam logic [3:0] RTOC_IDX_CONTROL = 4'h4;
   localparam logic [3:0] RTOC_IDX_OSC_CTRL = 4'h5;
   localparam logic [3:0] RTOC_IDX_ALARM0 = 4'h8;
   localparam logic [3:0] RTOC_IDX_ALARM3 = 4'hb;
   localparam logic [3:0] RTOC_IDX_IRQ_STATUS = 4'hc;
   localparam logic [3:0] RTOC_IDX_IRQ_MASK = 4'hd;
   localparam logic [3:0] RTOC_IDX_TIMER_NOW = 4'he;
   // control register fields
   localparam int RTOC_CTL_RUN = 4;
   localparam int RTOC_CTL_AEN = 3;
   localparam int RTOC_CTL_ALARM_FLAG_AUTORESET = 2;
   localparam int RTOC_CTL_SET = 1;
   localparam int RTOC_CTL_CAP = 0;
   // oscillator control fields
   localparam int RTOC_OSC_AGC = 7;
   localparam int RTOC_OSC_MODE = 6;
   localparam int RTOC_OSC_BIAS = 5;
   localparam int RTOC_OSC_VLD = 4;
   localparam int RTOC_OSC_LFO = 3;
   localparam logic [7:0] RTOC_OSC_RESET = 8'h00;
   // interrupt status bits
   localparam int RTOC_IRQ_ALARM = 0;
   localparam int RTOC_IRQ_SET_DONE = 1;
   localparam int RTOC_IRQ_CAP_DONE = 2;
   localparam logic [1:0] RTOC_RESP_OKAY = 2'b00;
   localparam logic [1:0] RTOC_RESP_SLVERR = 2'b10;
   // final count of a set or capture strobe, which stays high 3 cycles before it completes
   localparam logic [1:0] RTOC_XFER_CYCLES = 2'h2;
endpackage
`default_nettype wire

//--- rtl/rtoc_sync.sv
`default_nettype none
// two-flop synchroniser, two stages per bit
module rtoc_sync
   import rtoc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } rtoc_sync_t;
   rtoc_sync_t st, next_st;

   // the first stage feeds only the second
   always_comb begin
      next_st = st;
      if (clk_en) begin
         next_st.meta = async_in;
         next_st.stable = st.meta;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.stable;
endmodule
`default_nettype wire

//--- rtl/rtoc_timer.sv
`default_nettype none
// 32-bit timer with load, alarm compare
module rtoc_timer
   import rtoc_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic run,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   input wire logic [WIDTH-1:0] alarm_value,
   output logic [WIDTH-1:0] count,
   output logic match
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
   } rtoc_timer_t;
   rtoc_timer_t st, next_st;

   // load beats counting, so a set lands exactly on the loaded value
   always_comb begin
      next_st = st;
      if (clk_en) begin
         if (load) begin
            next_st.count = load_value;
         end else if (run) begin
            next_st.count = st.count + WIDTH'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count = st.count;
   assign match = run && (st.count == alarm_value);
endmodule
`default_nettype wire

//--- verification/rtoc_core_sva.sv
`default_nettype none
// watches the register bus, oscillator pins and alarm level
module rtoc_core_sva
   import rtoc_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic osc_amplitude_ok,
   input wire logic gain_control_enable,
   input wire logic oscillator_mode_select,
   input wire logic bias_double_enable,
   input wire logic low_freq_osc_select,
   input wire logic crystal_osc_enable,
   input wire logic alarm_active
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] aw_idx;
   logic [7:0] w_byte;
   logic ar_en;
   logic amp_q;
   logic [2:0] stab;
   wire logic ar_hs = s_axi_arvalid && s_axi_arready;
   // last write target; only one write is open, so these stay put
   always_ff @(posedge core_clk) begin
      if (reset) begin
         aw_idx <= '0;
         w_byte <= '0;
         ar_en <= 1'b0;
         amp_q <= 1'b0;
         stab <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_idx <= s_axi_awaddr[5:2];
         if (s_axi_wvalid && s_axi_wready) w_byte <= s_axi_wdata[7:0];
         if ($rose(s_axi_bvalid) && aw_idx == RTOC_IDX_CONTROL) begin
            ar_en <= w_byte[RTOC_CTL_ALARM_FLAG_AUTORESET];
         end
         amp_q <= osc_amplitude_ok;
         // saturating count: async input must settle past the synchroniser
         if (amp_q != osc_amplitude_ok) stab <= 3'h0;
         else if (stab != 3'h7) stab <= stab + 3'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   AST_RESET_ZERO: assert property (
      $fell(reset) |-> !gain_control_enable && !oscillator_mode_select &&
      !bias_double_enable && !low_freq_osc_select && !crystal_osc_enable)
      else $error("oscillator outputs not zero after reset");
   AST_OSC_WRITE: assert property (
      $rose(s_axi_bvalid) && aw_idx == RTOC_IDX_OSC_CTRL |->
      gain_control_enable == w_byte[7] && bias_double_enable == w_byte[5] &&
      oscillator_mode_select == w_byte[6] && low_freq_osc_select == w_byte[3])
      else $error("oscillator outputs differ from written byte");
   AST_SOURCE_SEL: assert property (
      crystal_osc_enable == (oscillator_mode_select && !low_freq_osc_select))
      else $error("crystal enable ignores source select");
   AST_LOW_ZERO: assert property (
      ar_hs && s_axi_araddr[5:2] == RTOC_IDX_OSC_CTRL |=>
      s_axi_rvalid && s_axi_rdata[2:0] == 3'h0)
      else $error("low oscillator bits not zero");
   AST_VALID_BIT: assert property (
      ar_hs && s_axi_araddr[5:2] == RTOC_IDX_OSC_CTRL && stab == 3'h7 |=>
      s_axi_rdata[RTOC_OSC_VLD] == osc_amplitude_ok)
      else $error("valid bit differs from amplitude input");
   AST_FLAG_READ: assert property (
      ar_hs && s_axi_araddr[5:2] == RTOC_IDX_CONTROL |=>
      s_axi_rdata[RTOC_CTL_ALARM_FLAG_AUTORESET] == $past(alarm_active))
      else $error("flag bit read differs from alarm level");
   AST_DISABLE_CLR: assert property (
      $rose(s_axi_bvalid) && aw_idx == RTOC_IDX_CONTROL &&
      !w_byte[RTOC_CTL_AEN] |-> ##[0:1] !alarm_active)
      else $error("alarm flag kept after disable");
   AST_AUTO_RESET: assert property (
      $rose(alarm_active) && ar_en |-> ##[1:2] !alarm_active)
      else $error("alarm flag not auto cleared");
endmodule
bind rtoc_core rtoc_core_sva rtoc_core_sva_inst (
   .core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .osc_amplitude_ok, .gain_control_enable,
   .oscillator_mode_select, .bias_double_enable, .low_freq_osc_select,
   .crystal_osc_enable, .alarm_active
);
`default_nettype wire

//--- verification/rtc_timer_osc_control_tb.sv
`default_nettype none
`define CHK(got, exp) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected %0t: got %h expected %h", $time, got, exp); \
   end \
end
module rtc_timer_osc_control_tb
   import rtoc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic [5:0] s_axi_awaddr = '0;
   logic [5:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic osc_amplitude_ok = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, gain_control_enable, oscillator_mode_select;
   logic bias_double_enable, low_freq_osc_select, crystal_osc_enable;
   logic alarm_active, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, t, tv, d, c;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int seed = 18;
   wire logic [3:0] osc_out = {gain_control_enable, oscillator_mode_select,
      bias_double_enable, low_freq_osc_select};
   rtoc_core rtoc_core_inst (
      .core_clk, .reset, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_amplitude_ok,
      .gain_control_enable, .oscillator_mode_select, .bias_double_enable,
      .low_freq_osc_select, .crystal_osc_enable, .alarm_active, .irq
   );
   always #5 core_clk = ~core_clk;
   task automatic stop_test();
      if (err_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // hang guard, far above the length of the sequence
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end
   // handshakes judged at the falling edge, acted on at the next rise
   task automatic wr(input logic [3:0] idx, input logic [7:0] v);
      logic a, w, b;
      logic [31:0] z;
      b = 1'b0;
      z = $random(seed);
      @(posedge core_clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {z[23:0], v};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b) begin
         @(negedge core_clk);
         a = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge core_clk);
         if (a) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
   endtask
   task automatic rd(input logic [3:0] idx);
      logic a, b;
      b = 1'b0;
      @(posedge core_clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!b) begin
         @(negedge core_clk);
         a = s_axi_arvalid && s_axi_arready;
         b = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge core_clk);
         if (a) s_axi_arvalid <= 1'b0;
         if (b) s_axi_rready <= 1'b0;
      end
   endtask
   task automatic strobe(input logic [7:0] v);
      int n;
      n = 0;
      d = 32'h0000_0003;
      wr(RTOC_IDX_CONTROL, v);
      while (d[1:0] != 2'b00 && n < 20) begin
         rd(RTOC_IDX_CONTROL);
         n++;
      end
      `CHK(d[1:0], 2'b00)
   endtask
   task automatic load(input logic [31:0] v);
      for (int k = 0; k < 4; k++) wr(RTOC_IDX_CAPTURE0 + 4'(k), v[8*k +: 8]);
      strobe(8'h02);
   endtask
   task automatic wait_alarm();
      int n;
      n = 0;
      while (alarm_active !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      `CHK(alarm_active, 1'b1)
   endtask
   function automatic logic [7:0] osc_exp(input logic [7:0] v, input logic a);
      return {v[7:5], a, v[3], 3'b000};
   endfunction
   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      rd(RTOC_IDX_OSC_CTRL);
      `CHK(d, 32'h0000_0000)
      for (int i = 0; i < 10; i++) begin
         t = (i == 0) ? 32'h0000_00ff : $random(seed);
         osc_amplitude_ok <= t[9];
         wr(RTOC_IDX_OSC_CTRL, t[7:0]);
         repeat (10) @(posedge core_clk);
         rd(RTOC_IDX_OSC_CTRL);
         `CHK(d[7:0], osc_exp(t[7:0], t[9]))
         `CHK(osc_out, {t[7:5], t[3]})
         `CHK(crystal_osc_enable, t[6] & ~t[3])
      end
      rd(4'h6);
      `CHK({r, d}, {RTOC_RESP_SLVERR, 32'h0000_0000})
      wr(4'h7, 8'h5a);
      `CHK(r, RTOC_RESP_SLVERR)
      t = $random(seed);
      t[31] = 1'b0;
      load(t);
      rd(RTOC_IDX_TIMER_NOW);
      `CHK(d, t)
      repeat (5) @(posedge core_clk);
      rd(RTOC_IDX_TIMER_NOW);
      `CHK(d, t)
      rd(RTOC_IDX_IRQ_STATUS);
      `CHK(d[RTOC_IRQ_SET_DONE], 1'b1)
      wr(RTOC_IDX_CONTROL, 8'h10);
      repeat (40) @(posedge core_clk);
      // clock enable low must freeze the running timer
      rd(RTOC_IDX_TIMER_NOW);
      c = d;
      clk_en <= 1'b0;
      repeat (30) @(posedge core_clk);
      clk_en <= 1'b1;
      rd(RTOC_IDX_TIMER_NOW);
      `CHK(d - c < 32'h0000_0008, 1'b1)
      wr(RTOC_IDX_CONTROL, 8'h00);
      rd(RTOC_IDX_TIMER_NOW);
      tv = d;
      `CHK(tv - t >= 32'h28 && tv - t <= 32'h3c, 1'b1)
      strobe(8'h01);
      for (int k = 0; k < 4; k++) begin
         rd(RTOC_IDX_CAPTURE0 + 4'(k));
         c[8*k +: 8] = d[7:0];
      end
      `CHK(c, tv)
      // alarm bytes only touched with the alarm off
      wr(RTOC_IDX_IRQ_MASK, 8'h01);
      load(t);
      tv = t + 32'h0000_001e;
      for (int k = 0; k < 4; k++) begin
         wr(RTOC_IDX_ALARM0 + 4'(k), tv[8*k +: 8]);
      end
      wr(RTOC_IDX_CONTROL, 8'h18);
      wait_alarm();
      rd(RTOC_IDX_CONTROL);
      `CHK(d[RTOC_CTL_ALARM_FLAG_AUTORESET], 1'b1)
      `CHK(irq, 1'b1)
      rd(RTOC_IDX_IRQ_STATUS);
      `CHK(d[RTOC_IRQ_ALARM], 1'b1)
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(irq, 1'b0)
      wr(RTOC_IDX_CONTROL, 8'h10);
      @(posedge core_clk);
      #1;
      `CHK(alarm_active, 1'b0)
      rd(RTOC_IDX_CONTROL);
      `CHK(d[3:2], 2'b00)
      wr(RTOC_IDX_CONTROL, 8'h00);
      load(t);
      wr(RTOC_IDX_CONTROL, 8'h1c);
      wait_alarm();
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(alarm_active, 1'b0)
      rd(RTOC_IDX_CONTROL);
      `CHK(d[RTOC_CTL_ALARM_FLAG_AUTORESET], 1'b0)
      // second reset in mid run
      @(posedge core_clk);
      reset <= 1'b1;
      // amplitude low, so the valid bit cannot race the reset check
      osc_amplitude_ok <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(RTOC_IDX_OSC_CTRL);
      `CHK(d, 32'h0000_0000)
      stop_test();
   end
endmodule
`default_nettype wire
